// *** hdl/serial_port2_pin_mux.sv ***
// pin multiplexer for serial port two, prom serial pins and gpio bit eight
//
// Summary of operation
// - pci on, port strap off: tie off
// - two straps together pick pin owners
// - clock source pin, or software gpio eight
// - pci mode: transmit clock pin becomes prom clock output
// - pci mode: receive data feeds prom input
// - pci mode: transmit data drives prom output
// - no pci variant: serial functions only
// - auto-init strap only honoured with pci
`timescale 1ns/1ps
`default_nettype none
`include "sp2_mux_defines.svh"

module serial_port2_pin_mux #(
  parameter bit HAS_PCI = 1'b1
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic [1:0]       avs_response_o,
  // straps
  input  wire logic        pci_enable_strap_i,
  input  wire logic        serial_port2_enable_strap_i,
  input  wire logic        eeprom_auto_init_strap_i,
  // serial port core side
  input  wire logic        sp_clkx_out_i,
  input  wire logic        sp_clkx_oe_n_i,
  input  wire logic        sp_clkr_out_i,
  input  wire logic        sp_clkr_oe_n_i,
  input  wire logic        sp_fsr_out_i,
  input  wire logic        sp_fsr_oe_n_i,
  input  wire logic        sp_fsx_out_i,
  input  wire logic        sp_fsx_oe_n_i,
  input  wire logic        sp_dx_out_i,
  input  wire logic        sp_dx_oe_n_i,
  output logic             sp_clks_o,
  output logic             sp_clkx_in_o,
  output logic             sp_clkr_in_o,
  output logic             sp_fsr_in_o,
  output logic             sp_fsx_in_o,
  output logic             sp_dr_o,
  // prom controller side
  input  wire logic        prom_serial_clock_i,
  input  wire logic        prom_serial_data_out_i,
  output logic             prom_serial_data_in_o,
  output logic             prom_autoinit_o,
  // pins
  input  wire logic        sp2_ext_clock_source_pin_i,
  output logic             sp2_ext_clock_source_pin_o,
  output logic             sp2_ext_clock_source_pin_oe_n_o,
  input  wire logic        sp2_transmit_clock_pin_i,
  output logic             sp2_transmit_clock_pin_o,
  output logic             sp2_transmit_clock_pin_oe_n_o,
  input  wire logic        sp2_receive_clock_pin_i,
  output logic             sp2_receive_clock_pin_o,
  output logic             sp2_receive_clock_pin_oe_n_o,
  input  wire logic        sp2_receive_frame_sync_pin_i,
  output logic             sp2_receive_frame_sync_pin_o,
  output logic             sp2_receive_frame_sync_pin_oe_n_o,
  input  wire logic        sp2_transmit_frame_sync_pin_i,
  output logic             sp2_transmit_frame_sync_pin_o,
  output logic             sp2_transmit_frame_sync_pin_oe_n_o,
  input  wire logic        sp2_receive_data_pin_i,
  output logic             sp2_transmit_data_pin_o,
  output logic             sp2_transmit_data_pin_oe_n_o
);

  // ==========================================================================
  // strap latch
  sp2_mux_cfg_if cfg_bus ();

  sp2_strap_latch #(
    .HAS_PCI                     (HAS_PCI)
  ) u_strap (
    .ref_clk_i                   (ref_clk_i),
    .sys_rst_i                   (sys_rst_i),
    .pci_enable_strap_i          (pci_enable_strap_i),
    .serial_port2_enable_strap_i (serial_port2_enable_strap_i),
    .eeprom_auto_init_strap_i    (eeprom_auto_init_strap_i),
    .cfg                         (cfg_bus.src)
  );

  wire logic prom_w;
  wire logic off_w;
  wire logic run_w;
  assign prom_w = cfg_bus.prom_mode;
  assign off_w  = cfg_bus.sp_off;
  // pins stay released until the straps are latched
  assign run_w  = cfg_bus.latched;

  // ==========================================================================
  // bus decode
  logic [2:0]  ctrl_r;
  logic        ack_r;
  wire logic   req_w;
  wire logic   hit_ctrl_w;
  wire logic   hit_stat_w;
  wire logic   wr_ctrl_w;
  wire logic [31:0] stat_w;
  wire logic [31:0] rd_w;

  assign req_w      = (avs_read_i | avs_write_i) & ~ack_r;
  assign hit_ctrl_w = (avs_address_i == `SP2_REG_CTRL);
  assign hit_stat_w = (avs_address_i == `SP2_REG_STATUS);
  // write lands on the edge where the master sees waitrequest low
  assign wr_ctrl_w  = ack_r & avs_write_i & hit_ctrl_w & avs_byteenable_i[0];

  assign stat_w = {24'h00_0000,
                   cfg_bus.strap_err,
                   cfg_bus.latched,
                   sp2_ext_clock_source_pin_i,
                   off_w,
                   prom_w,
                   cfg_bus.autoinit,
                   serial_port2_enable_strap_i,
                   pci_enable_strap_i};
  assign rd_w = hit_ctrl_w ? {29'h0000_0000, ctrl_r} :
                hit_stat_w ? stat_w : 32'h0000_0000;

  // one wait cycle, answer on the second edge of each request
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      ack_r             <= 1'b0;
      ctrl_r            <= `SP2_CTRL_RST;
      avs_readdata_o    <= 32'h0000_0000;
      avs_waitrequest_o <= 1'b1;
      avs_response_o    <= 2'h0;
    end else begin
      ack_r             <= req_w;
      avs_waitrequest_o <= ~req_w;
      if (wr_ctrl_w)
        ctrl_r <= avs_writedata_i[2:0];
      if (req_w) begin
        avs_readdata_o <= avs_read_i ? rd_w : 32'h0000_0000;
        avs_response_o <= (hit_ctrl_w | hit_stat_w) ? 2'h0 : 2'h2;
      end
    end
  end

  // ==========================================================================
  // pin selection
  wire logic gpio_w;
  assign gpio_w = ctrl_r[`SP2_CTRL_GPIO_SEL];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sp2_ext_clock_source_pin_o         <= 1'b0;
      sp2_ext_clock_source_pin_oe_n_o    <= 1'b1;
      sp2_transmit_clock_pin_o           <= 1'b0;
      sp2_transmit_clock_pin_oe_n_o      <= 1'b1;
      sp2_receive_clock_pin_o            <= 1'b0;
      sp2_receive_clock_pin_oe_n_o       <= 1'b1;
      sp2_receive_frame_sync_pin_o       <= 1'b0;
      sp2_receive_frame_sync_pin_oe_n_o  <= 1'b1;
      sp2_transmit_frame_sync_pin_o      <= 1'b0;
      sp2_transmit_frame_sync_pin_oe_n_o <= 1'b1;
      sp2_transmit_data_pin_o            <= 1'b0;
      sp2_transmit_data_pin_oe_n_o       <= 1'b1;
      sp_clks_o             <= 1'b0;
      sp_clkx_in_o          <= 1'b0;
      sp_clkr_in_o          <= 1'b0;
      sp_fsr_in_o           <= 1'b0;
      sp_fsx_in_o           <= 1'b0;
      sp_dr_o               <= 1'b0;
      prom_serial_data_in_o <= 1'b0;
      prom_autoinit_o       <= 1'b0;
    end else begin
      // clock source pin: input only unless software claims gpio
      sp2_ext_clock_source_pin_o      <= ctrl_r[`SP2_CTRL_GPIO_OUT];
      sp2_ext_clock_source_pin_oe_n_o <= ~(gpio_w & ctrl_r[`SP2_CTRL_GPIO_OE]);
      sp_clks_o <= gpio_w ? 1'b0 : sp2_ext_clock_source_pin_i;
      // transmit clock pin
      sp2_transmit_clock_pin_o <= prom_w ? prom_serial_clock_i : sp_clkx_out_i;
      sp2_transmit_clock_pin_oe_n_o <= ~run_w | (prom_w ? 1'b0 : sp_clkx_oe_n_i);
      sp_clkx_in_o <= prom_w ? 1'b0 : sp2_transmit_clock_pin_i;
      // data pins
      sp2_transmit_data_pin_o <= prom_w ? prom_serial_data_out_i : sp_dx_out_i;
      sp2_transmit_data_pin_oe_n_o <= ~run_w | (prom_w ? 1'b0 : sp_dx_oe_n_i);
      prom_serial_data_in_o <= prom_w & sp2_receive_data_pin_i;
      sp_dr_o <= prom_w ? 1'b0 : sp2_receive_data_pin_i;
      // frame syncs and receive clock driven low when the port is off
      sp2_receive_clock_pin_o <= off_w ? `SP2_TIE_LEVEL : sp_clkr_out_i;
      sp2_receive_clock_pin_oe_n_o <= ~run_w | (off_w ? 1'b0 : sp_clkr_oe_n_i);
      sp2_receive_frame_sync_pin_o <= off_w ? `SP2_TIE_LEVEL : sp_fsr_out_i;
      sp2_receive_frame_sync_pin_oe_n_o <= ~run_w | (off_w ? 1'b0 : sp_fsr_oe_n_i);
      sp2_transmit_frame_sync_pin_o <= off_w ? `SP2_TIE_LEVEL : sp_fsx_out_i;
      sp2_transmit_frame_sync_pin_oe_n_o <= ~run_w | (off_w ? 1'b0 : sp_fsx_oe_n_i);
      sp_clkr_in_o <= off_w ? 1'b0 : sp2_receive_clock_pin_i;
      sp_fsr_in_o  <= off_w ? 1'b0 : sp2_receive_frame_sync_pin_i;
      sp_fsx_in_o  <= off_w ? 1'b0 : sp2_transmit_frame_sync_pin_i;
      prom_autoinit_o <= cfg_bus.autoinit;
    end
  end

endmodule

`default_nettype wire

// *** hdl/sp2_mux_cfg_if.sv ***
// interface carrying latched pin ownership between mux modules
`timescale 1ns/1ps
`default_nettype none

interface sp2_mux_cfg_if;
  logic      latched;
  logic      prom_mode;
  logic      sp_off;
  logic      autoinit;
  logic      strap_err;
  modport    src (output latched, output prom_mode, output sp_off, output autoinit,
                  output strap_err);
  modport    dst (input latched, input prom_mode, input sp_off, input autoinit,
                  input strap_err);
endinterface

`default_nettype wire

// *** hdl/sp2_mux_defines.svh ***
// constants for the serial port two pin multiplexer
`ifndef SP2_MUX_DEFINES_SVH
`define SP2_MUX_DEFINES_SVH

// ==========================================================================
// register byte offsets
`define SP2_REG_CTRL      4'h0
`define SP2_REG_STATUS    4'h4
// ==========================================================================
// control field positions and reset value
`define SP2_CTRL_GPIO_SEL 0
`define SP2_CTRL_GPIO_OUT 1
`define SP2_CTRL_GPIO_OE  2
`define SP2_CTRL_RST      3'h0
// ==========================================================================
// status field positions
`define SP2_ST_PCI_EN     0
`define SP2_ST_SP_EN      1
`define SP2_ST_AUTOINIT   2
`define SP2_ST_PROM_MODE  3
`define SP2_ST_SP_OFF     4
`define SP2_ST_GPIO_IN    5
`define SP2_ST_LATCHED    6
`define SP2_ST_STRAP_ERR  7
// ==========================================================================
// tie-off level of the disabled pins
`define SP2_TIE_LEVEL     1'b0

`endif

// *** hdl/sp2_mux_pkg.sv ***
// types for the serial port two pin multiplexer
`default_nettype none
package sp2_mux_pkg;

  // pin ownership, gray in list order; reset -> prom flips both bits
  typedef enum logic [1:0] {
    OWN_RESET   = 2'b00,
    OWN_SERIAL  = 2'b01,
    OWN_PROM    = 2'b11,
    OWN_OFF     = 2'b10
  } owner_type;

endpackage

`default_nettype wire

// *** hdl/sp2_strap_latch.sv ***
// strap capture after reset release and pin ownership decode
`timescale 1ns/1ps
`default_nettype none

module sp2_strap_latch #(
  parameter bit HAS_PCI = 1'b1
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  // straps
  input  wire logic        pci_enable_strap_i,
  input  wire logic        serial_port2_enable_strap_i,
  input  wire logic        eeprom_auto_init_strap_i,
  // decoded ownership
  sp2_mux_cfg_if.src       cfg
);

  sp2_mux_pkg::owner_type  own_r;
  sp2_mux_pkg::owner_type  own_nxt;
  logic                    auto_r;
  logic                    err_r;
  wire logic               pci_eff;
  wire logic               auto_ok;

  // without the pci peripheral every strap reads as serial port only
  assign pci_eff = HAS_PCI & pci_enable_strap_i;
  // auto-init only legal with pci enabled
  assign auto_ok = pci_eff & eeprom_auto_init_strap_i;

  // ==========================================================================
  // ownership decision, taken once on the first edge after reset
  always_comb begin
    own_nxt = own_r;
    case (own_r)
      sp2_mux_pkg::OWN_RESET: begin
        if (!pci_eff)
          own_nxt = sp2_mux_pkg::OWN_SERIAL;
        else if (!serial_port2_enable_strap_i)
          own_nxt = sp2_mux_pkg::OWN_OFF;
        else
          own_nxt = sp2_mux_pkg::OWN_PROM;
      end
      sp2_mux_pkg::OWN_SERIAL,
      sp2_mux_pkg::OWN_PROM,
      sp2_mux_pkg::OWN_OFF: own_nxt = own_r;
      default: own_nxt = sp2_mux_pkg::OWN_RESET;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      own_r  <= sp2_mux_pkg::OWN_RESET;
      auto_r <= 1'b0;
      err_r  <= 1'b0;
    end else if (own_r == sp2_mux_pkg::OWN_RESET) begin
      own_r  <= own_nxt;
      auto_r <= auto_ok;
      err_r  <= eeprom_auto_init_strap_i & ~pci_eff;
    end
  end

  assign cfg.latched   = (own_r != sp2_mux_pkg::OWN_RESET);
  assign cfg.prom_mode = (own_r == sp2_mux_pkg::OWN_PROM) | (own_r == sp2_mux_pkg::OWN_OFF);
  assign cfg.sp_off    = (own_r == sp2_mux_pkg::OWN_OFF);
  assign cfg.autoinit  = auto_r;
  assign cfg.strap_err = err_r;

endmodule

`default_nettype wire

// *** testbench/sp2_mux_checker.sv ***
// concurrent checks on the serial port two pin multiplexer ports
`timescale 1ns/1ps
`default_nettype none
module sp2_mux_checker #(
  parameter bit HAS_PCI = 1'b1
) (
  // clock, reset, bus
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // straps and core side
  input wire logic pci_enable_strap_i,
  input wire logic serial_port2_enable_strap_i,
  input wire logic eeprom_auto_init_strap_i,
  input wire logic sp_clkx_out_i,
  input wire logic sp_clkx_oe_n_i,
  input wire logic sp_fsx_out_i,
  input wire logic sp_fsx_oe_n_i,
  input wire logic sp_dr_o,
  input wire logic prom_serial_clock_i,
  input wire logic prom_serial_data_out_i,
  input wire logic prom_serial_data_in_o,
  input wire logic prom_autoinit_o,
  // pins
  input wire logic sp2_receive_data_pin_i,
  input wire logic sp2_transmit_clock_pin_o,
  input wire logic sp2_transmit_clock_pin_oe_n_o,
  input wire logic sp2_transmit_data_pin_o,
  input wire logic sp2_transmit_data_pin_oe_n_o,
  input wire logic sp2_receive_clock_pin_o,
  input wire logic sp2_receive_clock_pin_oe_n_o,
  input wire logic sp2_receive_frame_sync_pin_o,
  input wire logic sp2_receive_frame_sync_pin_oe_n_o,
  input wire logic sp2_transmit_frame_sync_pin_o,
  input wire logic sp2_transmit_frame_sync_pin_oe_n_o
);
  // ==========================================================================
  // own copy of the strap capture, valid once the pins drive
  logic lat_r, vld_r, pci_r, port_r, ai_r;
  wire  prom_w = HAS_PCI & pci_r;
  wire  off_w  = prom_w & ~port_r;
  always_ff @(posedge ref_clk_i) begin
    lat_r <= ~sys_rst_i;
    vld_r <= ~sys_rst_i & lat_r;
    if (!sys_rst_i && !lat_r) begin
      pci_r  <= pci_enable_strap_i;
      port_r <= serial_port2_enable_strap_i;
      ai_r   <= eeprom_auto_init_strap_i;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  // ==========================================================================
  // checks
  a_bus_one_wait: assert property (s_taken |=> s_answer)
    else $error("bus answer timing wrong");
  a_prom_clock_out: assert property (vld_r && prom_w |-> !sp2_transmit_clock_pin_oe_n_o
    && sp2_transmit_clock_pin_o == $past(prom_serial_clock_i)) else $error("prom clock pin wrong");
  a_serial_clock: assert property (vld_r && !prom_w |->
    sp2_transmit_clock_pin_oe_n_o == $past(sp_clkx_oe_n_i) && (sp2_transmit_clock_pin_oe_n_o
    || sp2_transmit_clock_pin_o == $past(sp_clkx_out_i))) else $error("serial clock pin wrong");
  a_prom_data_out: assert property (vld_r && prom_w |-> !sp2_transmit_data_pin_oe_n_o
    && sp2_transmit_data_pin_o == $past(prom_serial_data_out_i)) else $error("prom data pin wrong");
  a_prom_data_in: assert property (vld_r && prom_w |-> !sp_dr_o
    && prom_serial_data_in_o == $past(sp2_receive_data_pin_i)) else $error("prom data in wrong");
  a_serial_data_in: assert property (vld_r && !prom_w |-> !prom_serial_data_in_o
    && sp_dr_o == $past(sp2_receive_data_pin_i)) else $error("receive data wrong");
  a_tie_frames: assert property (vld_r && off_w |->
    !(sp2_receive_clock_pin_oe_n_o | sp2_receive_frame_sync_pin_oe_n_o
    | sp2_transmit_frame_sync_pin_oe_n_o) && !(sp2_receive_clock_pin_o
    | sp2_receive_frame_sync_pin_o | sp2_transmit_frame_sync_pin_o)) else $error("tie-off wrong");
  a_serial_frame: assert property (vld_r && !off_w |->
    sp2_transmit_frame_sync_pin_oe_n_o == $past(sp_fsx_oe_n_i) && (sp2_transmit_frame_sync_pin_oe_n_o
    || sp2_transmit_frame_sync_pin_o == $past(sp_fsx_out_i))) else $error("frame pin wrong");
  a_autoinit_gate: assert property (vld_r |-> prom_autoinit_o == (prom_w & ai_r))
    else $error("auto-init gating wrong");
endmodule
bind serial_port2_pin_mux sp2_mux_checker #(.HAS_PCI(HAS_PCI)) chk (.*);
`default_nettype wire

// *** testbench/sp2_prom_model.sv ***
// behavioural serial prom seen through the multiplexed pins
`timescale 1ns/1ps
`default_nettype none
module sp2_prom_model (
  // pins
  input  wire logic clk_i,
  input  wire logic en_i,
  input  wire logic di_i,
  output logic      do_o
);
  logic q = 1'b1;
  // data from the device lands on the clock edge
  always @(posedge clk_i) q <= di_i;
  // answers the inverse; unselected, the pin falls to its pull-up
  assign do_o = en_i ? ~q : 1'b1;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench for the serial port two pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ==========================================================================
  // stimulus and observed signals
  logic ref_clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd;
  logic [1:0] avs_response_o, rs;
  logic avs_waitrequest_o, pv = 1'b0, coe_n = 1'b0, pm = 1'b0;
  logic pci_enable_strap_i = 1'b0, serial_port2_enable_strap_i = 1'b1, eeprom_auto_init_strap_i = 1'b1;
  wire sp_clkx_out_i = pv, sp_clkr_out_i = ~pv, sp_fsr_out_i = pv, sp_fsx_out_i = pv, sp_dx_out_i = ~pv;
  wire sp_clkx_oe_n_i = coe_n, sp_clkr_oe_n_i = coe_n, sp_fsr_oe_n_i = coe_n;
  wire sp_fsx_oe_n_i = coe_n, sp_dx_oe_n_i = coe_n;
  logic sp_clks_o, sp_clkx_in_o, sp_clkr_in_o, sp_fsr_in_o, sp_fsx_in_o, sp_dr_o;
  logic prom_serial_clock_i = 1'b0, prom_serial_data_out_i = 1'b0, prom_serial_data_in_o, prom_autoinit_o;
  logic sp2_ext_clock_source_pin_o, sp2_ext_clock_source_pin_oe_n_o, sp2_transmit_data_pin_o;
  logic sp2_transmit_clock_pin_o, sp2_transmit_clock_pin_oe_n_o, sp2_transmit_data_pin_oe_n_o;
  logic sp2_receive_clock_pin_o, sp2_receive_clock_pin_oe_n_o, sp2_receive_frame_sync_pin_o;
  logic sp2_receive_frame_sync_pin_oe_n_o, sp2_transmit_frame_sync_pin_o, sp2_transmit_frame_sync_pin_oe_n_o;
  wire sp2_receive_data_pin_i;
  // pin level resolved from the device enable, pattern when released
  wire sp2_ext_clock_source_pin_i = sp2_ext_clock_source_pin_oe_n_o ? pv : sp2_ext_clock_source_pin_o;
  wire sp2_transmit_clock_pin_i = sp2_transmit_clock_pin_oe_n_o ? pv : sp2_transmit_clock_pin_o;
  wire sp2_receive_clock_pin_i = sp2_receive_clock_pin_oe_n_o ? pv : sp2_receive_clock_pin_o;
  wire sp2_receive_frame_sync_pin_i = sp2_receive_frame_sync_pin_oe_n_o ? pv : sp2_receive_frame_sync_pin_o;
  wire sp2_transmit_frame_sync_pin_i = sp2_transmit_frame_sync_pin_oe_n_o ? pv
                                       : sp2_transmit_frame_sync_pin_o;
  int err_total = 0, tests_run = 0;
  serial_port2_pin_mux #(.HAS_PCI(1'b1)) dut (.*);
  sp2_prom_model prom (.clk_i(sp2_transmit_clock_pin_o), .en_i(pm), .di_i(sp2_transmit_data_pin_o),
                       .do_o(sp2_receive_data_pin_i));
  initial forever #20 ref_clk_i = ~ref_clk_i;
  // ==========================================================================
  // tasks
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t bit got %b exp %b", $time, g, e);
    end
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t word got %h exp %h", $time, g, e);
    end
  endtask
  // one bus cycle; wait state count left to the slave, bounded here
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o;
    rs = avs_response_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("[ERR] %0t bus timeout", $time);
      finish_test();
    end
    @(posedge ref_clk_i);
  endtask
  task automatic do_reset(input logic pci, input logic port);
    pci_enable_strap_i <= pci;
    serial_port2_enable_strap_i <= port;
    sys_rst_i <= 1'b1;
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    pci_enable_strap_i <= ~pci;
    serial_port2_enable_strap_i <= ~port;
  endtask
  // ==========================================================================
  // every pci and port strap combination, then gpio bit eight and the bus refusals
  initial begin
    for (int m = 0; m < 4; m++) begin
      do_reset(m[1], m[0]);
      pm <= m[1];
      for (int k = 0; k < 2; k++) begin
        pv <= k[0];
        coe_n <= k[0];
        prom_serial_data_out_i <= k[0];
        prom_serial_clock_i <= 1'b0;
        // outputs read mid-cycle, once the launching edge has settled
        @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk_bit(sp2_transmit_clock_pin_o, ~m[1] & k[0]);
        chk_bit(sp2_transmit_data_pin_o, m[1] ~^ k[0]);
        @(posedge ref_clk_i);
        prom_serial_clock_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk_bit(sp2_transmit_clock_pin_o, m[1] | k[0]);
        chk_bit(prom_serial_data_in_o, m[1] & ~k[0]);
        chk_bit(sp_dr_o, ~m[1]);
        chk_bit(sp2_transmit_frame_sync_pin_o, ~(m[1] & ~m[0]) & k[0]);
        chk_bit(sp2_receive_frame_sync_pin_oe_n_o, ~(m[1] & ~m[0]) & k[0]);
        chk_bit(sp2_receive_clock_pin_o, ~(m[1] & ~m[0]) & ~k[0]);
        chk_bit(sp_clkx_in_o, ~m[1] & k[0]);
        chk_bit(sp_clkr_in_o, ~(m[1] & ~m[0]));
        chk_bit(sp_fsr_in_o, ~(m[1] & ~m[0]) & k[0]);
        chk_bit(sp_fsx_in_o, ~(m[1] & ~m[0]) & k[0]);
        chk_bit(prom_autoinit_o, m[1]);
        @(posedge ref_clk_i);
      end
      bus(1'b0, 4'h4, 32'h0, 4'hf);
      // strap bits show the live pins, inverted since the latch
      chk_word(rd, {24'h0, ~m[1], 2'b11, m[1] & ~m[0], m[1], m[1], ~m[0], ~m[1]});
      $display("strap combination %0d done", m);
    end
    @(negedge ref_clk_i);
    chk_bit(sp2_ext_clock_source_pin_oe_n_o, 1'b1);
    chk_bit(sp_clks_o, 1'b1);
    @(posedge ref_clk_i);
    bus(1'b1, 4'h0, 32'h7, 4'hf);
    bus(1'b1, 4'h0, 32'h0, 4'he);
    bus(1'b0, 4'h0, 32'h0, 4'hf);
    chk_word(rd, 32'h7);
    @(negedge ref_clk_i);
    chk_bit(sp2_ext_clock_source_pin_oe_n_o, 1'b0);
    chk_bit(sp2_ext_clock_source_pin_o, 1'b1);
    chk_bit(sp_clks_o, 1'b0);
    @(posedge ref_clk_i);
    bus(1'b0, 4'h8, 32'h0, 4'hf);
    chk_word({rs, rd[29:0]}, 32'h80000000);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk_bit(sp_clks_o, 1'b1);
    $display("gpio and bus test done");
    finish_test();
  end
endmodule
`default_nettype wire
